// file: tcc_channel.sv
`timescale 1ns/10ps
module tcc_channel
#(
  parameter int CNT_W = 16
) (
  input  wire logic                       SYS_CLK_I,
  input  wire logic                       SYS_RST_I,
  input  wire logic [tcc_pkg::ADDR_W-1:0] BUS_ADDR_I,
  input  wire logic [31:0]                BUS_WDATA_I,
  input  wire logic                       BUS_WR_I,
  input  wire logic                       BUS_RD_I,
  output logic      [31:0]                BUS_RDATA_O,
  input  wire logic [2:0]                 EXT_CLK_I,
  input  wire logic                       IO_FIRST_I,
  output logic                            IO_FIRST_O,
  output logic                            IO_FIRST_OE_O,
  input  wire logic                       IO_SECOND_I,
  output logic                            IO_SECOND_O,
  output logic                            IO_SECOND_OE_O
);

  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       rise,
                                    input logic       fall);
    logic r;
    r = 1'b0;
    case (sel)
      tcc_pkg::SEL_1: r = rise;
      tcc_pkg::SEL_2: r = fall;
      tcc_pkg::SEL_3: r = rise | fall;
      default:        r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic eff_apply(input logic       cur,
                                     input logic [1:0] code);
    logic r;
    r = cur;
    case (code)
      tcc_pkg::EFF_SET:    r = 1'b1;
      tcc_pkg::EFF_CLEAR:  r = 1'b0;
      tcc_pkg::EFF_TOGGLE: r = ~cur;
      default:             r = cur;
    endcase
    return r;
  endfunction

  logic [31:0]             mode_q;
  logic [CNT_W-1:0]        cnt_q;
  logic [CNT_W-1:0]        ra_q;
  logic [CNT_W-1:0]        rb_q;
  logic [CNT_W-1:0]        rc_q;
  logic [CNT_W-1:0]        cnt_nx;
  logic [tcc_pkg::PRE_W-1:0] pre_q;
  logic                    clk_en_q;
  logic                    run_q;
  logic                    sclk_prev_q;
  logic [2:0]              xc_prev_q;
  logic                    ioa_prev_q;
  logic                    iob_prev_q;
  logic [1:0]              line_q;
  logic [1:0]              oe_q;
  logic [31:0]             rdata_q;

  logic       wave;
  logic       wr_cmd;
  logic       swt;
  logic       sclk_src;
  logic       sclk;
  logic       tick;
  logic       inc;
  logic       ioa_rise;
  logic       ioa_fall;
  logic       iob_rise;
  logic       iob_fall;
  logic [2:0] xc_rise;
  logic [2:0] xc_fall;
  logic       trig_rise;
  logic       trig_fall;
  logic       ev_rise;
  logic       ev_fall;
  logic       ev_hit;
  logic       ext_trig;
  logic       ld_a;
  logic       ld_b;
  logic       match_a;
  logic       match_b;
  logic       match_c;
  logic       rc_trig;
  logic       stop_ev;
  logic       dis_ev;
  logic       line_b_out;
  logic [1:0] match_own;

  assign wave   = mode_q[tcc_pkg::M_WAVE];
  assign wr_cmd = BUS_WR_I && (BUS_ADDR_I == tcc_pkg::OFF_CMD);
  assign swt    = wr_cmd && BUS_WDATA_I[tcc_pkg::CMD_SWT];

  // free prescaler; its taps are the divided master clocks
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      pre_q <= '0;
    else
      pre_q <= pre_q + 1'b1;
  end

  always_comb
  begin
    case (mode_q[tcc_pkg::M_CLKS +: 3])
      tcc_pkg::CLKS_DIV2:    sclk_src = pre_q[tcc_pkg::DIV2_BIT];
      tcc_pkg::CLKS_DIV8:    sclk_src = pre_q[tcc_pkg::DIV8_BIT];
      tcc_pkg::CLKS_DIV32:   sclk_src = pre_q[tcc_pkg::DIV32_BIT];
      tcc_pkg::CLKS_DIV128:  sclk_src = pre_q[tcc_pkg::DIV128_BIT];
      tcc_pkg::CLKS_DIV1024: sclk_src = pre_q[tcc_pkg::DIV1024_BIT];
      tcc_pkg::CLKS_XC0:     sclk_src = EXT_CLK_I[0];
      tcc_pkg::CLKS_XC1:     sclk_src = EXT_CLK_I[1];
      default:               sclk_src = EXT_CLK_I[2];
    endcase
    case (mode_q[tcc_pkg::M_BURST +: 2])
      tcc_pkg::SEL_1: sclk = sclk_src & EXT_CLK_I[0];
      tcc_pkg::SEL_2: sclk = sclk_src & EXT_CLK_I[1];
      tcc_pkg::SEL_3: sclk = sclk_src & EXT_CLK_I[2];
      default:        sclk = sclk_src;
    endcase
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      sclk_prev_q <= 1'b0;
      xc_prev_q   <= '0;
      ioa_prev_q  <= 1'b0;
      iob_prev_q  <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= sclk;
      xc_prev_q   <= EXT_CLK_I;
      ioa_prev_q  <= IO_FIRST_I;
      iob_prev_q  <= IO_SECOND_I;
    end
  end

  // counting edge of the selected, gated clock
  assign tick = mode_q[tcc_pkg::M_CLOCK_EDGE_INVERT] ? (sclk_prev_q & ~sclk)
                                        : (~sclk_prev_q & sclk);
  assign inc    = tick & clk_en_q & run_q;
  assign cnt_nx = cnt_q + 1'b1;

  assign ioa_rise = IO_FIRST_I & ~ioa_prev_q;
  assign ioa_fall = ~IO_FIRST_I & ioa_prev_q;
  assign iob_rise = IO_SECOND_I & ~iob_prev_q;
  assign iob_fall = ~IO_SECOND_I & iob_prev_q;
  assign xc_rise  = EXT_CLK_I & ~xc_prev_q;
  assign xc_fall  = ~EXT_CLK_I & xc_prev_q;

  // capture mode trigger line
  assign trig_rise = mode_q[tcc_pkg::M_LINESEL] ? ioa_rise : iob_rise;
  assign trig_fall = mode_q[tcc_pkg::M_LINESEL] ? ioa_fall : iob_fall;

  // waveform mode event source
  always_comb
  begin
    case (mode_q[tcc_pkg::M_EVSRC +: 2])
      tcc_pkg::SEL_1:
      begin
        ev_rise = xc_rise[0];
        ev_fall = xc_fall[0];
      end
      tcc_pkg::SEL_2:
      begin
        ev_rise = xc_rise[1];
        ev_fall = xc_fall[1];
      end
      tcc_pkg::SEL_3:
      begin
        ev_rise = xc_rise[2];
        ev_fall = xc_fall[2];
      end
      default:
      begin
        ev_rise = iob_rise;
        ev_fall = iob_fall;
      end
    endcase
  end

  assign ev_hit = wave &&
                  edge_hit(mode_q[tcc_pkg::M_EDGE +: 2], ev_rise, ev_fall);
  assign ext_trig = wave ? (ev_hit && mode_q[tcc_pkg::M_EVENT_TRIGGER_EN])
                         : edge_hit(mode_q[tcc_pkg::M_EDGE +: 2],
                                    trig_rise, trig_fall);
  assign ld_a = !wave &&
                edge_hit(mode_q[tcc_pkg::M_RA_LOAD_EDGE +: 2], ioa_rise, ioa_fall);
  assign ld_b = !wave &&
                edge_hit(mode_q[tcc_pkg::M_RB_LOAD_EDGE +: 2], ioa_rise, ioa_fall);

  // compares fire on the tick that brings the counter to the value
  assign match_a   = inc && (cnt_nx == ra_q);
  assign match_b   = inc && (cnt_nx == rb_q);
  assign match_c   = inc && (cnt_nx == rc_q);
  assign match_own = {match_b, match_a};
  assign rc_trig   = match_c && mode_q[tcc_pkg::M_RC_COMPARE_TRIGGER_EN];

  assign stop_ev = mode_q[tcc_pkg::M_STOP] &&
                   (wave ? match_c : ld_b);
  assign dis_ev  = mode_q[tcc_pkg::M_DIS] &&
                   (wave ? match_c : ld_b);

  // clock enable: disable command, then disabling events, then enable
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      clk_en_q <= 1'b0;
    else if (wr_cmd && BUS_WDATA_I[tcc_pkg::CMD_DIS])
      clk_en_q <= 1'b0;
    else if (dis_ev)
      clk_en_q <= 1'b0;
    else if (wr_cmd && BUS_WDATA_I[tcc_pkg::CMD_EN])
      clk_en_q <= 1'b1;
  end

  // run: started by triggers, halted by the stop options
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      run_q <= 1'b0;
    else if (swt || ext_trig)
      run_q <= 1'b1;
    else if (stop_ev)
      run_q <= 1'b0;
    else if (rc_trig)
      run_q <= 1'b1;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      cnt_q <= '0;
    else if (swt || ext_trig || rc_trig)
      cnt_q <= '0;
    else if (inc)
      cnt_q <= cnt_nx;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      mode_q <= tcc_pkg::MODE_RST;
    else if (BUS_WR_I && (BUS_ADDR_I == tcc_pkg::OFF_MODE))
      mode_q <= BUS_WDATA_I;
  end

  // A and B capture in capture mode, writable only in waveform mode
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      ra_q <= '0;
      rb_q <= '0;
    end
    else
    begin
      if (ld_a)
        ra_q <= cnt_q;
      else if (wave && BUS_WR_I && (BUS_ADDR_I == tcc_pkg::OFF_RA))
        ra_q <= BUS_WDATA_I[CNT_W-1:0];
      if (ld_b)
        rb_q <= cnt_q;
      else if (wave && BUS_WR_I && (BUS_ADDR_I == tcc_pkg::OFF_RB))
        rb_q <= BUS_WDATA_I[CNT_W-1:0];
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
      rc_q <= '0;
    else if (BUS_WR_I && (BUS_ADDR_I == tcc_pkg::OFF_RC))
      rc_q <= BUS_WDATA_I[CNT_W-1:0];
  end

  // second line drives only when the event is not taken from it
  assign line_b_out = wave &&
                      (mode_q[tcc_pkg::M_EVSRC +: 2] != tcc_pkg::SEL_0);

  // output lines: only the highest-priority coinciding event acts
  for (genvar i = 0; i < 2; i++)
  begin : g_line
    localparam int BASE = (i == 0) ? tcc_pkg::M_LINE_A : tcc_pkg::M_LINE_B;
    always_ff @(posedge SYS_CLK_I)
    begin
      if (SYS_RST_I)
      begin
        line_q[i] <= 1'b0;
        oe_q[i]   <= 1'b0;
      end
      else
      begin
        oe_q[i] <= (i == 0) ? wave : line_b_out;
        if (!wave)
          line_q[i] <= line_q[i];
        else if (swt)
          line_q[i] <= eff_apply(line_q[i],
                                 mode_q[BASE + tcc_pkg::EFF_SW +: 2]);
        else if (ev_hit)
          line_q[i] <= eff_apply(line_q[i],
                                 mode_q[BASE + tcc_pkg::EFF_EV +: 2]);
        else if (match_c)
          line_q[i] <= eff_apply(line_q[i],
                                 mode_q[BASE + tcc_pkg::EFF_RC +: 2]);
        else if (match_own[i])
          line_q[i] <= eff_apply(line_q[i],
                                 mode_q[BASE + tcc_pkg::EFF_OWN +: 2]);
      end
    end
  end

  assign IO_FIRST_O     = line_q[0];
  assign IO_SECOND_O    = line_q[1];
  assign IO_FIRST_OE_O  = oe_q[0];
  assign IO_SECOND_OE_O = oe_q[1];

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I || !BUS_RD_I)
      rdata_q <= '0;
    else
    begin
      rdata_q <= '0;
      case (BUS_ADDR_I)
        tcc_pkg::OFF_MODE: rdata_q <= mode_q;
        tcc_pkg::OFF_CNT:  rdata_q[CNT_W-1:0] <= cnt_q;
        tcc_pkg::OFF_RA:   rdata_q[CNT_W-1:0] <= ra_q;
        tcc_pkg::OFF_RB:   rdata_q[CNT_W-1:0] <= rb_q;
        tcc_pkg::OFF_RC:   rdata_q[CNT_W-1:0] <= rc_q;
        tcc_pkg::OFF_STAT:
        begin
          rdata_q[tcc_pkg::STAT_CLKSTA] <= clk_en_q;
          rdata_q[tcc_pkg::STAT_LINE_A] <= IO_FIRST_I;
          rdata_q[tcc_pkg::STAT_LINE_B] <= IO_SECOND_I;
          rdata_q[tcc_pkg::STAT_RUN]    <= run_q;
        end
        default:           rdata_q <= '0;
      endcase
    end
  end

  assign BUS_RDATA_O = rdata_q;

  default clocking @(posedge SYS_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  en_dis_wins_a: assert property (
    wr_cmd && BUS_WDATA_I[tcc_pkg::CMD_EN] && BUS_WDATA_I[tcc_pkg::CMD_DIS]
    |=> !clk_en_q)
    else $error("enable beat a simultaneous disable");
  dis_cmd_a: assert property (wr_cmd && BUS_WDATA_I[tcc_pkg::CMD_DIS]
    |=> !clk_en_q && !inc)
    else $error("clock still enabled after disable command");
  soft_trig_a: assert property (swt |=> cnt_q == '0 && run_q)
    else $error("soft trigger did not clear and start counter");
  count_edge_a: assert property (
    cnt_q != $past(cnt_q) && cnt_q != '0 |-> $past(tick) && $past(clk_en_q))
    else $error("counter moved without a counting edge");
  rb_stop_a: assert property (
    !wave && ld_b && mode_q[tcc_pkg::M_STOP] && !swt && !ext_trig
    |=> !run_q)
    else $error("clock not stopped on B capture");
  rb_dis_a: assert property (
    !wave && ld_b && mode_q[tcc_pkg::M_DIS] |=> !clk_en_q)
    else $error("clock not disabled on B capture");
  rc_trig_a: assert property (rc_trig |=> cnt_q == '0)
    else $error("compare C trigger did not clear counter");
  ra_load_a: assert property (ld_a |=> ra_q == $past(cnt_q))
    else $error("capture A did not take counter value");
  rc_stop_a: assert property (
    wave && match_c && mode_q[tcc_pkg::M_STOP] && !swt && !ext_trig
    |=> !run_q ##1 ($past(swt || ext_trig) || cnt_q == $past(cnt_q)))
    else $error("clock not stopped at compare C");
  rc_dis_a: assert property (
    wave && match_c && mode_q[tcc_pkg::M_DIS] |=> !clk_en_q)
    else $error("clock not disabled at compare C");
  line_prio_a: assert property (
    wave && swt && (ev_hit || match_c) |=>
    line_q[0] == eff_apply($past(line_q[0]),
                 $past(mode_q[tcc_pkg::M_LINE_A + tcc_pkg::EFF_SW +: 2])))
    else $error("soft trigger effect lost priority");

endmodule

// file: tcc_channel_tb_top.sv
`timescale 1ns/10ps
module tcc_channel_tb_top;
  logic                       clk;
  logic                       rst;
  logic [tcc_pkg::ADDR_W-1:0] addr;
  logic [31:0]                wdata;
  logic                       wr;
  logic                       rd;
  logic [31:0]                rdata;
  logic [2:0]                 ext_lvl;
  logic [2:0]                 ext_clk;
  logic                       first_lvl;
  logic                       second_lvl;
  logic                       first_pin;
  logic                       second_pin;
  logic                       first_o;
  logic                       first_oe;
  logic                       second_o;
  logic                       second_oe;
  logic [31:0]                exp_q[$];
  logic [31:0]                msk_q[$];
  int                         tol_q[$];
  string                      nam_q[$];
  int                         fail_count;
  int                         checked;
  int                         cycles;
  int                         seed;
  logic                       rd_d;

  tcc_channel tcc_channel_i (
    .SYS_CLK_I(clk), .SYS_RST_I(rst), .BUS_ADDR_I(addr),
    .BUS_WDATA_I(wdata), .BUS_WR_I(wr), .BUS_RD_I(rd),
    .BUS_RDATA_O(rdata), .EXT_CLK_I(ext_clk), .IO_FIRST_I(first_pin),
    .IO_FIRST_O(first_o), .IO_FIRST_OE_O(first_oe),
    .IO_SECOND_I(second_pin), .IO_SECOND_O(second_o),
    .IO_SECOND_OE_O(second_oe)
  );

  tcc_line_model tcc_line_model_i (
    .ext_lvl_i(ext_lvl), .first_lvl_i(first_lvl), .second_lvl_i(second_lvl),
    .first_drv_i(first_o), .first_oe_i(first_oe), .second_drv_i(second_o),
    .second_oe_i(second_oe), .ext_clk_o(ext_clk), .first_pin_o(first_pin),
    .second_pin_o(second_pin)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp_read(input string nm, input logic [31:0] got,
                          input logic [31:0] e, input logic [31:0] m,
                          input int t);
    logic ok;
    ok = 1'b0;
    for (int j = -t; j <= t; j++)
      if ((got & m) === ((e + 32'(j)) & m))
        ok = 1'b1;
    checked++;
    if (!ok)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e & m, got & m);
    end
  endtask

  task automatic cmp_line(input string nm, input logic got, input logic e);
    checked++;
    if (got !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, got);
    end
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rd_d)
      cmp_read(nam_q.pop_front(), rdata, exp_q.pop_front(),
               msk_q.pop_front(), tol_q.pop_front());
    rd_d = rd;
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic bus(input logic w, input logic r, input logic [7:0] a,
                     input logic [31:0] d);
    wr    <= w;
    rd    <= r;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
  endtask

  task automatic cyc(input int n);
    repeat (n) bus(1'b0, 1'b0, addr, wdata);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic rreg(input string nm, input logic [7:0] a,
                      input logic [31:0] e, input logic [31:0] m,
                      input int t);
    nam_q.push_back(nm);
    exp_q.push_back(e);
    msk_q.push_back(m);
    tol_q.push_back(t);
    bus(1'b0, 1'b1, a, 32'h0);
  endtask

  task automatic rcnt(input logic [31:0] e, input int t);
    rreg("counter", tcc_pkg::OFF_CNT, e, 32'hFFFF, t);
  endtask

  task automatic rsta(input logic [31:0] e, input logic [31:0] m);
    rreg("status", tcc_pkg::OFF_STAT, e, m, 0);
  endtask

  task automatic setup(input logic [31:0] mode, input logic [31:0] cmd);
    wreg(tcc_pkg::OFF_MODE, mode);
    wreg(tcc_pkg::OFF_CMD, cmd);
  endtask

  task automatic pulse(input int l, input int n);
    repeat (n)
    begin
      ext_lvl[l] <= 1'b1;
      cyc(2);
      ext_lvl[l] <= 1'b0;
      cyc(2);
    end
  endtask

  task automatic first_edges();
    first_lvl <= 1'b1;
    cyc(2);
    first_lvl <= 1'b0;
    cyc(2);
  endtask

  initial
  begin
    int k;
    int sh[5];
    int code[4];
    int lvl[4];
    sh = '{1, 3, 5, 7, 10};
    code = '{1, 2, 3, 3};
    lvl = '{1, 0, 1, 0};
    {rst, wr, rd, addr, wdata, rd_d} = {1'b1, 1'b0, 1'b0, 8'h00, 32'h0, 1'b0};
    {ext_lvl, first_lvl, second_lvl} = 5'h00;
    {fail_count, checked, cycles} = {32'h0, 32'h0, 32'h0};
    seed = 32'h6E37F8FE;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    rreg("mode", tcc_pkg::OFF_MODE, tcc_pkg::MODE_RST, '1, 0);
    rreg("command", tcc_pkg::OFF_CMD, 32'h0, '1, 0);
    rreg("unmapped", 8'h08, 32'h0, '1, 0);
    rsta(32'h0, 32'h0009_0000);
    wreg(tcc_pkg::OFF_CMD, 32'h3);
    rsta(32'h0, 32'h0001_0000);
    wreg(tcc_pkg::OFF_CMD, 32'h1);
    wreg(tcc_pkg::OFF_CMD, 32'h0);
    rsta(32'h0001_0000, 32'h0001_0000);
    wreg(tcc_pkg::OFF_CMD, 32'h2);
    rsta(32'h0, 32'h0001_0000);
    for (int c = 0; c < 5; c++)
    begin
      setup(32'(c), 32'h5);
      cyc(2047);
      rcnt(32'(2048 >> sh[c]), 1);
    end
    for (int c = 5; c < 8; c++)
    begin
      k = 1 + ($unsigned($random(seed)) % 8);
      setup(32'(c), 32'h5);
      pulse(c - 5, k);
      rcnt(32'(k), 0);
    end
    for (int v = 0; v < 2; v++)
    begin
      setup(32'h5 | 32'(v << 3), 32'h5);
      ext_lvl[0] <= 1'b1;
      cyc(2);
      rcnt(32'(1 - v), 0);
      ext_lvl[0] <= 1'b0;
      cyc(2);
      rcnt(32'h1, 0);
    end
    for (int g = 2; g < 4; g++)
    begin
      setup(32'h5 | 32'(g << 4), 32'h5);
      pulse(0, 3);
      rcnt(32'h0, 0);
      ext_lvl[g - 1] <= 1'b1;
      pulse(0, 3);
      ext_lvl[g - 1] <= 1'b0;
      rcnt(32'h3, 0);
    end
    wreg(tcc_pkg::OFF_RC, 32'h3);
    setup(32'h0000_C005, 32'h5);
    pulse(0, 5);
    rcnt(32'h2, 0);
    setup(32'h0000_8045, 32'h5);
    pulse(0, 5);
    rcnt(32'h3, 0);
    rsta(32'h0001_0000, 32'h0009_0000);
    wreg(tcc_pkg::OFF_CMD, 32'h4);
    rsta(32'h0009_0000, 32'h0009_0000);
    setup(32'h0000_8085, 32'h5);
    pulse(0, 5);
    rcnt(32'h3, 0);
    rsta(32'h0, 32'h0001_0000);
    wreg(tcc_pkg::OFF_CMD, 32'h4);
    pulse(0, 2);
    rcnt(32'h0, 0);
    wreg(tcc_pkg::OFF_CMD, 32'h1);
    pulse(0, 2);
    rcnt(32'h2, 0);
    setup(32'h0009_0045, 32'h5);
    pulse(0, 4);
    first_lvl <= 1'b1;
    cyc(2);
    pulse(0, 2);
    first_lvl <= 1'b0;
    cyc(2);
    pulse(0, 3);
    wreg(tcc_pkg::OFF_RA, 32'h55);
    rreg("reg_a", tcc_pkg::OFF_RA, 32'h4, 32'hFFFF, 0);
    rreg("reg_b", tcc_pkg::OFF_RB, 32'h6, 32'hFFFF, 0);
    rcnt(32'h6, 0);
    setup(32'h0008_0085, 32'h5);
    pulse(0, 2);
    first_edges();
    rsta(32'h0, 32'h0001_0000);
    for (int s = 0; s < 2; s++)
    begin
      setup(32'h105 | 32'(s << 10), 32'h5);
      pulse(0, 3);
      if (s == 0)
        second_lvl <= 1'b1;
      else
        first_lvl <= 1'b1;
      cyc(2);
      rcnt(32'h0, 0);
      pulse(0, 2);
      second_lvl <= 1'b0;
      first_lvl <= 1'b0;
      cyc(2);
      rcnt(32'h2, 0);
    end
    setup(32'h0000_9E06, 32'h5);
    pulse(1, 3);
    cmp_line("first_oe", first_oe, 1'b1);
    cmp_line("second_oe", second_oe, 1'b1);
    ext_lvl[2] <= 1'b1;
    cyc(2);
    rcnt(32'h3, 0);
    ext_lvl[2] <= 1'b0;
    cyc(2);
    rcnt(32'h0, 0);
    wreg(tcc_pkg::OFF_MODE, 32'h0000_8206);
    cyc(2);
    cmp_line("second_oe", second_oe, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      setup(32'h8400 | (32'(code[i]) << 22) | (32'(code[i]) << 30), 32'h4);
      cyc(1);
      rsta(lvl[i] ? 32'h0006_0000 : 32'h0, 32'h0006_0000);
    end
    wreg(tcc_pkg::OFF_RA, 32'h2);
    wreg(tcc_pkg::OFF_RC, 32'h2);
    setup(32'h0086_8005, 32'h5);
    pulse(0, 2);
    rreg("reg_a", tcc_pkg::OFF_RA, 32'h2, 32'hFFFF, 0);
    rsta(32'h0002_0000, 32'h0002_0000);
    // soft trigger (set) and a rising event (clear) in the same cycle
    wreg(tcc_pkg::OFF_MODE, 32'h0060_8500);
    ext_lvl[0] <= 1'b1;
    wreg(tcc_pkg::OFF_CMD, 32'h4);
    ext_lvl[0] <= 1'b0;
    cyc(1);
    rsta(32'h0002_0000, 32'h0002_0000);
    cyc(3);
    print_verdict();
  end
endmodule

// file: tcc_line_model.sv
`timescale 1ns/10ps
module tcc_line_model (
  input  wire logic [2:0] ext_lvl_i,
  input  wire logic       first_lvl_i,
  input  wire logic       second_lvl_i,
  input  wire logic       first_drv_i,
  input  wire logic       first_oe_i,
  input  wire logic       second_drv_i,
  input  wire logic       second_oe_i,
  output logic      [2:0] ext_clk_o,
  output logic            first_pin_o,
  output logic            second_pin_o
);
  // external clocks are synchronous levels from the far side
  assign ext_clk_o    = ext_lvl_i;
  // the far side only shows its own level where the channel lets go
  assign first_pin_o  = first_oe_i ? first_drv_i : first_lvl_i;
  assign second_pin_o = second_oe_i ? second_drv_i : second_lvl_i;
endmodule

// file: tcc_pkg.sv
package tcc_pkg;

  // register byte offsets
  localparam int         ADDR_W    = 8;
  localparam logic [7:0] OFF_CMD   = 8'h00;
  localparam logic [7:0] OFF_MODE  = 8'h04;
  localparam logic [7:0] OFF_CNT   = 8'h10;
  localparam logic [7:0] OFF_RA    = 8'h14;
  localparam logic [7:0] OFF_RB    = 8'h18;
  localparam logic [7:0] OFF_RC    = 8'h1C;
  localparam logic [7:0] OFF_STAT  = 8'h20;

  // channel_command bits
  localparam int CMD_EN  = 0;
  localparam int CMD_DIS = 1;
  localparam int CMD_SWT = 2;

  // channel_mode fields (shared positions in both modes)
  localparam int          M_CLKS     = 0;
  localparam int          M_CLOCK_EDGE_INVERT     = 3;
  localparam int          M_BURST    = 4;
  localparam int          M_STOP     = 6;
  localparam int          M_DIS      = 7;
  localparam int          M_EDGE     = 8;
  localparam int          M_LINESEL  = 10;
  localparam int          M_EVSRC    = 10;
  localparam int          M_EVENT_TRIGGER_EN   = 12;
  localparam int          M_RC_COMPARE_TRIGGER_EN   = 14;
  localparam int          M_WAVE     = 15;
  localparam int          M_RA_LOAD_EDGE     = 16;
  localparam int          M_RB_LOAD_EDGE     = 18;
  localparam int          M_LINE_A   = 16;
  localparam int          M_LINE_B   = 24;
  localparam int          EFF_OWN    = 0;
  localparam int          EFF_RC     = 2;
  localparam int          EFF_EV     = 4;
  localparam int          EFF_SW     = 6;
  localparam logic [31:0] MODE_RST   = 32'h0000_0000;

  // status bits
  localparam int STAT_CLKSTA = 16;
  localparam int STAT_LINE_A = 17;
  localparam int STAT_LINE_B = 18;
  localparam int STAT_RUN    = 19;

  // prescaler taps: bit k of a free counter has period 2^(k+1)
  localparam int PRE_W       = 10;
  localparam int DIV2_BIT    = 0;
  localparam int DIV8_BIT    = 2;
  localparam int DIV32_BIT   = 4;
  localparam int DIV128_BIT  = 6;
  localparam int DIV1024_BIT = 9;

  localparam logic [2:0] CLKS_DIV2    = 3'h0;
  localparam logic [2:0] CLKS_DIV8    = 3'h1;
  localparam logic [2:0] CLKS_DIV32   = 3'h2;
  localparam logic [2:0] CLKS_DIV128  = 3'h3;
  localparam logic [2:0] CLKS_DIV1024 = 3'h4;
  localparam logic [2:0] CLKS_XC0     = 3'h5;
  localparam logic [2:0] CLKS_XC1     = 3'h6;
  localparam logic [2:0] CLKS_XC2     = 3'h7;

  localparam logic [1:0] SEL_0 = 2'h0;
  localparam logic [1:0] SEL_1 = 2'h1;
  localparam logic [1:0] SEL_2 = 2'h2;
  localparam logic [1:0] SEL_3 = 2'h3;

  typedef enum logic [1:0] {
    EFF_NONE   = 2'h0,
    EFF_SET    = 2'h1,
    EFF_CLEAR  = 2'h2,
    EFF_TOGGLE = 2'h3
  } tcc_eff_e;

endpackage
